// ---- logic/i2cm_top.v ----
// Purpose: I2C master sequencer: Start, Repeated Start, Stop, byte transmit, collisions.
// Assumes: AHB-Lite slave, 32-bit words, open-drain SCL/SDA pins, one 20 MHz clock.
// Notes: Open-drain pins; during byte transmit SDA moves one clock after SCL is pulled low.
// Contract
// - Buffer write while busy dropped, sets collision
// - Low five control bits locked during Start
// - Start with lines high loads baud counter
// - Expiry with lines high: SDA low, flag
// - Second period ends Start, clears request
// - Lines low or SCL low aborts Start
// - Restart: SCL low, then SDA released
// - Release SCL, high period, SDA low
// - Restart ends SCL low, flag after timeout
// - Restart ignored while other event running
// - Restart collision on SDA or SCL low
// - Idle buffer write sets full, starts sending
// - Bit after SCL falls, low/high periods
// - Eighth fall clears full, releases SDA
// - Ninth bit stored as acknowledge status
// - After ninth clock: interrupt flag, halt
// - Seven address bits then direction bit
// - Counter waits for SCL high, reloads
// - Stop: SDA low, SCL up, SDA up
`timescale 1ns/10ps
`include "i2cm_map.vh"

module i2cm_top (
	input wire i_clk,
	input wire i_srst,
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [2:0] i_hsize,
	input wire [31:0] i_hwdata,
	input wire i_hready,
	output reg [31:0] o_hrdata,
	output reg o_hreadyout,
	output reg o_hresp,
	input wire i_scl,
	output reg o_scl_o,
	output reg o_scl_oe,
	input wire i_sda,
	output reg o_sda_o,
	output reg o_sda_oe
);
	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [4:0] S_IDLE = 5'h00;
	localparam [4:0] S_ST_WAIT = 5'h01;
	localparam [4:0] S_ST_HOLD = 5'h02;
	localparam [4:0] S_RS_SCLLO = 5'h03;
	localparam [4:0] S_RS_SDAHI = 5'h04;
	localparam [4:0] S_RS_SCLREL = 5'h05;
	localparam [4:0] S_RS_HIGH = 5'h06;
	localparam [4:0] S_RS_SDALO = 5'h07;
	localparam [4:0] S_TX_LOW = 5'h08;
	localparam [4:0] S_TX_REL = 5'h09;
	localparam [4:0] S_TX_HIGH = 5'h0A;
	localparam [4:0] S_SP_SDALO = 5'h0B;
	localparam [4:0] S_SP_LOW = 5'h0C;
	localparam [4:0] S_SP_REL = 5'h0D;
	localparam [4:0] S_SP_HIGH = 5'h0E;
	localparam [4:0] S_SP_WAIT = 5'h0F;
	localparam [4:0] S_SP_END = 5'h10;

	wire scl_in;
	wire sda_in;
	reg [4:0] state_q;
	reg [7:0] cnt_q;
	reg [7:0] baud_q;
	reg [7:0] txbuf_q;
	reg [7:0] sh_q;
	reg [3:0] bit_q;
	reg sda_upd_q;
	reg start_q;
	reg restart_request_q;
	reg pen_q;
	reg sdet_q;
	reg pdet_q;
	reg bf_q;
	reg ack_q;
	reg write_collision_flag_q;
	reg bcol_q;
	reg pif_q;
	reg wr_q;
	reg [3:0] wofs_q;
	wire expire;
	wire busy;
	wire in_start;
	wire tx_write;
	wire ctrl_write;
	wire stat_write;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	i2cm_sync #(.RST_VAL(1'b1)) u_sync_scl (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_pin(i_scl),
		.o_level(scl_in)
	);
	i2cm_sync #(.RST_VAL(1'b1)) u_sync_sda (
		.i_clk(i_clk),
		.i_srst(i_srst),
		.i_pin(i_sda),
		.o_level(sda_in)
	);

	// ----------------------------------------
	// Bus slave
	// ----------------------------------------
	function is_ofs;
		input [31:0] addr;
		input [3:0] ofs;
		begin
			is_ofs = (addr[31:4] == 28'h0000000) && (addr[3:0] == ofs);
		end
	endfunction

	function [31:0] rd_mux;
		input [31:0] addr;
		begin
			rd_mux = 32'h00000000;
			if (is_ofs(addr, `I2CM_OFS_CTRL)) begin
				rd_mux = {29'h00000000, pen_q, restart_request_q, start_q};
			end else if (is_ofs(addr, `I2CM_OFS_STAT)) begin
				rd_mux = {24'h000000, busy, pif_q, bcol_q, write_collision_flag_q, ack_q, bf_q, pdet_q, sdet_q};
			end else if (is_ofs(addr, `I2CM_OFS_BAUD)) begin
				rd_mux = {24'h000000, baud_q};
			end else if (is_ofs(addr, `I2CM_OFS_TXB)) begin
				rd_mux = {24'h000000, txbuf_q};
			end
		end
	endfunction

	// Zero wait states; unmapped reads give zero, writes are dropped
	always @(posedge i_clk) begin
		if (i_srst) begin
			wr_q <= 1'b0;
			wofs_q <= 4'h0;
			o_hrdata <= 32'h00000000;
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end else begin
			wr_q <= 1'b0;
			if (i_hsel && i_htrans[1] && i_hready) begin
				if (i_hwrite) begin
					wr_q <= (i_haddr[31:4] == 28'h0000000) && (i_haddr[1:0] == 2'h0);
					wofs_q <= i_haddr[3:0];
				end else begin
					o_hrdata <= rd_mux(i_haddr);
				end
			end
		end
	end

	assign ctrl_write = wr_q && (wofs_q == `I2CM_OFS_CTRL);
	assign stat_write = wr_q && (wofs_q == `I2CM_OFS_STAT);
	assign tx_write = wr_q && (wofs_q == `I2CM_OFS_TXB);
	assign busy = (state_q != S_IDLE) || start_q || restart_request_q || pen_q;
	assign in_start = start_q || (state_q == S_ST_WAIT) || (state_q == S_ST_HOLD);
	assign expire = (cnt_q == 8'h00);

	// ----------------------------------------
	// Collision abort: lines released, requests dropped
	// ----------------------------------------
	task do_abort;
		begin
			bcol_q <= 1'b1;
			start_q <= 1'b0;
			restart_request_q <= 1'b0;
			pen_q <= 1'b0;
			bf_q <= 1'b0;
			sda_upd_q <= 1'b0;
			o_scl_oe <= 1'b0;
			o_sda_oe <= 1'b0;
			state_q <= S_IDLE;
		end
	endtask

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always @(posedge i_clk) begin
		if (i_srst) begin
			state_q <= S_IDLE;
			cnt_q <= 8'h00;
			baud_q <= `I2CM_BAUD_RST;
			txbuf_q <= 8'h00;
			sh_q <= 8'h00;
			sda_upd_q <= 1'b0;
			bit_q <= 4'h0;
			start_q <= 1'b0;
			restart_request_q <= 1'b0;
			pen_q <= 1'b0;
			sdet_q <= 1'b0;
			pdet_q <= 1'b0;
			bf_q <= 1'b0;
			ack_q <= 1'b0;
			write_collision_flag_q <= 1'b0;
			bcol_q <= 1'b0;
			pif_q <= 1'b0;
			o_scl_o <= 1'b0;
			o_scl_oe <= 1'b0;
			o_sda_o <= 1'b0;
			o_sda_oe <= 1'b0;
		end else begin
			if (!expire) begin
				cnt_q <= cnt_q - 8'h01;
			end
			// Software side; hardware sets below win over these clears
			if (wr_q && (wofs_q == `I2CM_OFS_BAUD)) begin
				baud_q <= i_hwdata[7:0];
			end
			if (stat_write) begin
				sdet_q <= sdet_q & ~i_hwdata[`I2CM_ST_SDET];
				pdet_q <= pdet_q & ~i_hwdata[`I2CM_ST_PDET];
				write_collision_flag_q <= write_collision_flag_q & ~i_hwdata[`I2CM_ST_WRITE_COLLISION_FLAG];
				bcol_q <= bcol_q & ~i_hwdata[`I2CM_ST_BCOL];
				pif_q <= pif_q & ~i_hwdata[`I2CM_ST_PIF];
			end
			// No queuing: requests only land when nothing is running
			if (ctrl_write && !in_start && !busy) begin
				start_q <= i_hwdata[`I2CM_CTRL_START];
				restart_request_q <= i_hwdata[`I2CM_CTRL_RESTART];
				pen_q <= i_hwdata[`I2CM_CTRL_STOP];
			end
			if (tx_write && busy) begin
				write_collision_flag_q <= 1'b1;
			end
			case (state_q)
				S_IDLE: begin
					if (start_q) begin
						if (scl_in && sda_in) begin
							cnt_q <= baud_q;
							state_q <= S_ST_WAIT;
						end else if (!scl_in && !sda_in) begin
							do_abort;
						end
					end else if (restart_request_q) begin
						o_scl_oe <= 1'b1;
						state_q <= S_RS_SCLLO;
					end else if (pen_q) begin
						o_scl_oe <= 1'b1;
						o_sda_oe <= 1'b1;
						state_q <= S_SP_SDALO;
					end else if (tx_write) begin
						txbuf_q <= i_hwdata[7:0];
						sh_q <= i_hwdata[7:0];
						bf_q <= 1'b1;
						bit_q <= 4'h0;
						o_scl_oe <= 1'b1;
						sda_upd_q <= 1'b1;
						cnt_q <= baud_q;
						state_q <= S_TX_LOW;
					end
				end
				S_ST_WAIT: begin
					if (!scl_in) begin
						do_abort;
					end else if (expire) begin
						if (sda_in) begin
							o_sda_oe <= 1'b1;
							sdet_q <= 1'b1;
							cnt_q <= baud_q;
							state_q <= S_ST_HOLD;
						end else begin
							do_abort;
						end
					end
				end
				S_ST_HOLD: begin
					if (expire) begin
						start_q <= 1'b0;
						pif_q <= 1'b1;
						state_q <= S_IDLE;
					end
				end
				S_RS_SCLLO: begin
					if (!scl_in) begin
						cnt_q <= baud_q;
						o_sda_oe <= 1'b0;
						state_q <= S_RS_SDAHI;
					end
				end
				S_RS_SDAHI: begin
					if (expire) begin
						if (sda_in) begin
							o_scl_oe <= 1'b0;
							state_q <= S_RS_SCLREL;
						end else begin
							do_abort;
						end
					end
				end
				S_RS_SCLREL: begin
					if (scl_in) begin
						if (!sda_in) begin
							do_abort;
						end else begin
							cnt_q <= baud_q;
							state_q <= S_RS_HIGH;
						end
					end
				end
				S_RS_HIGH: begin
					if (!sda_in || !scl_in) begin
						do_abort;
					end else if (expire) begin
						o_sda_oe <= 1'b1;
						sdet_q <= 1'b1;
						cnt_q <= baud_q;
						state_q <= S_RS_SDALO;
					end
				end
				S_RS_SDALO: begin
					if (expire) begin
						o_scl_oe <= 1'b1;
						restart_request_q <= 1'b0;
						pif_q <= 1'b1;
						state_q <= S_IDLE;
					end
				end
				S_TX_LOW: begin
					// SDA never moves in the cycle SCL falls: a slave could read a false Start or Stop
					if (sda_upd_q) begin
						sda_upd_q <= 1'b0;
						if (bit_q == `I2CM_BITS_PER_BYTE) begin
							bf_q <= 1'b0;
							o_sda_oe <= 1'b0;
						end else begin
							o_sda_oe <= ~sh_q[7];
						end
					end else if (expire) begin
						o_scl_oe <= 1'b0;
						state_q <= S_TX_REL;
					end
				end
				S_TX_REL: begin
					// Slave may stretch; counting waits for SCL high
					if (scl_in) begin
						cnt_q <= baud_q;
						if (bit_q == `I2CM_BITS_PER_BYTE) begin
							ack_q <= sda_in;
						end
						state_q <= S_TX_HIGH;
					end
				end
				S_TX_HIGH: begin
					if ((bit_q != `I2CM_BITS_PER_BYTE) && !o_sda_oe && !sda_in) begin
						do_abort;
					end else if (expire) begin
						o_scl_oe <= 1'b1;
						if (bit_q == `I2CM_BITS_PER_BYTE) begin
							pif_q <= 1'b1;
							state_q <= S_IDLE;
						end else begin
							bit_q <= bit_q + 4'h1;
							sh_q <= {sh_q[6:0], 1'b0};
							cnt_q <= baud_q;
							sda_upd_q <= 1'b1;
							state_q <= S_TX_LOW;
						end
					end
				end
				S_SP_SDALO: begin
					if (!sda_in) begin
						cnt_q <= baud_q;
						state_q <= S_SP_LOW;
					end
				end
				S_SP_LOW: begin
					if (expire) begin
						o_scl_oe <= 1'b0;
						state_q <= S_SP_REL;
					end
				end
				S_SP_REL: begin
					if (scl_in) begin
						cnt_q <= baud_q;
						state_q <= S_SP_HIGH;
					end
				end
				S_SP_HIGH: begin
					if (expire) begin
						o_sda_oe <= 1'b0;
						state_q <= S_SP_WAIT;
					end
				end
				S_SP_WAIT: begin
					if (sda_in && scl_in) begin
						pdet_q <= 1'b1;
						cnt_q <= baud_q;
						state_q <= S_SP_END;
					end
				end
				S_SP_END: begin
					if (expire) begin
						pen_q <= 1'b0;
						pif_q <= 1'b1;
						state_q <= S_IDLE;
					end
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end
endmodule // i2cm_top

// ---- logic/i2cm_map.vh ----
// Purpose: Register map, field positions and reset values of the I2C master sequencer.
// Assumes: Word-aligned AHB-Lite register slots, byte offsets below.
// Notes: Definitions only.
`ifndef I2CM_MAP_VH
`define I2CM_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define I2CM_OFS_CTRL 4'h0
`define I2CM_OFS_STAT 4'h4
`define I2CM_OFS_BAUD 4'h8
`define I2CM_OFS_TXB 4'hC

// ----------------------------------------
// Control register bits
// ----------------------------------------
`define I2CM_CTRL_START 0
`define I2CM_CTRL_RESTART 1
`define I2CM_CTRL_STOP 2
`define I2CM_CTRL_LOCK_W 5

// ----------------------------------------
// Status register bits
// ----------------------------------------
`define I2CM_ST_SDET 0
`define I2CM_ST_PDET 1
`define I2CM_ST_BF 2
`define I2CM_ST_ACK 3
`define I2CM_ST_WRITE_COLLISION_FLAG 4
`define I2CM_ST_BCOL 5
`define I2CM_ST_PIF 6
`define I2CM_ST_BUSY 7

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define I2CM_BAUD_RST 8'h09
`define I2CM_BITS_PER_BYTE 4'h8

`endif

// ---- logic/i2cm_sync.v ----
// Purpose: Three-stage pin synchroniser with agreement filter.
// Assumes: Input is asynchronous to i_clk.
// Notes: Output follows when stages two and three agree.
`timescale 1ns/10ps

module i2cm_sync #(
	parameter RST_VAL = 1'b1
) (
	input wire i_clk,
	input wire i_srst,
	input wire i_pin,
	output reg o_level
);
	reg s1_q;
	reg s2_q;
	reg s3_q;

	always @(posedge i_clk) begin
		if (i_srst) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
			o_level <= RST_VAL;
		end else begin
			s1_q <= i_pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// First stage feeds the second only
			if (s2_q == s3_q) begin
				o_level <= s3_q;
			end
		end
	end
endmodule // i2cm_sync

// ---- tb/i2cm_top_properties.sv ----
// Purpose: Port-level checks of the I2C master sequencer.
// Assumes: Bench baud reload 3, one period of four clocks.
// Notes: Bound into i2cm_top.
`timescale 1ns/10ps

module i2cm_props (
	input logic i_clk,
	input logic i_srst,
	input logic i_hsel,
	input logic [31:0] i_haddr,
	input logic [1:0] i_htrans,
	input logic i_hwrite,
	input logic i_hready,
	input logic [31:0] o_hrdata,
	input logic o_hreadyout,
	input logic o_hresp,
	input logic i_scl,
	input logic o_scl_o,
	input logic o_scl_oe,
	input logic o_sda_o,
	input logic o_sda_oe
);
	// ----------------------------------------
	// Sequences and checks
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);
	sequence s_start;
		$rose(o_sda_oe) && i_scl && !o_scl_oe;
	endsequence
	sequence s_start_hold;
		(o_sda_oe && !o_scl_oe) [*3];
	endsequence
	ahb_ok_a: assert property (o_hreadyout && !o_hresp) else $error("bus answer not ready or not okay");
	unmapped_zero_a: assert property (i_hsel && i_htrans[1] && !i_hwrite && i_hready && i_haddr[31:4] != 28'h0
		|=> o_hrdata == 32'h0) else $error("unmapped read not zero");
	pins_drain_a: assert property (!o_scl_o && !o_sda_o) else $error("pin driven high");
	start_hold_a: assert property (s_start |=> s_start_hold) else $error("start low phase too short");
	scl_high_min_a: assert property ($rose(i_scl) |-> !o_scl_oe [*5]) else $error("scl high too short");
	scl_low_min_a: assert property ($rose(o_scl_oe) |-> o_scl_oe [*4]) else $error("scl low too short");
	stretch_hold_a: assert property (!o_scl_oe && !i_scl |=> !o_scl_oe) else $error("scl pulled in stretch");
	stop_order_a: assert property ($fell(o_sda_oe) && !o_scl_oe |-> $past(o_scl_oe, 4) == 1'b0)
		else $error("sda released before scl period");
endmodule // i2cm_props

bind i2cm_top i2cm_props u_props (.i_clk, .i_srst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hready,
	.o_hrdata, .o_hreadyout, .o_hresp, .i_scl, .o_scl_o, .o_scl_oe, .o_sda_o, .o_sda_oe);

// ---- tb/i2cm_slave_model.sv ----
// Purpose: Behavioural I2C slave at the far side of the master.
// Assumes: Open-drain wires, pull-ups made by the bench.
// Notes: Acks or refuses on command, may stretch SCL.
`timescale 1ns/10ps

module i2cm_slave_model (
	input wire i_scl,
	input wire i_sda,
	input wire i_nack,
	input wire i_stretch,
	output reg o_scl_low,
	output reg o_sda_low,
	output reg [7:0] o_rx
);
	integer n;
	initial begin
		o_scl_low = 0;
		o_sda_low = 0;
		o_rx = 8'h00;
		n = 0;
	end
	// Start or repeated start restarts the count
	always @(negedge i_sda) if (i_scl) n = 0;
	always @(posedge i_scl) begin
		if (n < 8) o_rx = {o_rx[6:0], i_sda};
		n = n + 1;
	end
	always @(negedge i_scl) begin
		if (i_stretch) begin
			o_scl_low = 1;
			// Released off the master's clock edges, so sampling never races
			#510;
			o_scl_low = 0;
		end
		o_sda_low = (n == 8) && !i_nack;
		if (n >= 9) n = 0;
	end
endmodule // i2cm_slave_model

// ---- tb/i2cm_top_tb.sv ----
// Purpose: Self-checking bench of the I2C master sequencer.
// Assumes: Baud reload 3, one period of four clocks.
// Notes: Bench pull on both lines forces a collision.
`timescale 1ns/10ps
`include "i2cm_map.vh"

module i2cm_top_tb;
	logic i_clk, i_srst, hsel, hwrite, nack, str, bpull;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, v;
	wire [31:0] hrdata;
	wire rdy, resp, scl_o, scl_oe, sda_o, sda_oe, s_scl, s_sda;
	wire [7:0] rx;
	wire scl_w = ~(scl_oe | s_scl | bpull);
	wire sda_w = ~(sda_oe | s_sda | bpull);
	integer err_count, n_compared, k, k2;
	i2cm_top dut (.i_clk, .i_srst, .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(hrdata), .o_hreadyout(rdy),
		.o_hresp(resp), .i_scl(scl_w), .o_scl_o(scl_o), .o_scl_oe(scl_oe), .i_sda(sda_w),
		.o_sda_o(sda_o), .o_sda_oe(sda_oe));
	i2cm_slave_model u_slv (.i_scl(scl_w), .i_sda(sda_w), .i_nack(nack), .i_stretch(str),
		.o_scl_low(s_scl), .o_sda_low(s_sda), .o_rx(rx));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task stop_test;
		begin
			$display("compared %0d, mismatches %0d", n_compared, err_count);
			if (err_count == 0 && n_compared > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	task chk(input [31:0] g, input [31:0] e);
		begin
			n_compared = n_compared + 1;
			if (g !== e) begin
				err_count = err_count + 1;
				$display("unexpected at %0t: got %h want %h", $time, g, e);
			end
		end
	endtask
	task rdy_wait;
		begin
			k = 0;
			@(posedge i_clk);
			while (rdy !== 1'b1) begin
				k = k + 1;
				if (k > 50) begin
					err_count = err_count + 1;
					stop_test;
				end
				@(posedge i_clk);
			end
		end
	endtask
	// One single word transfer; read data lands in v
	task bus(input w, input [31:0] a, input [31:0] d);
		begin
			@(posedge i_clk);
			hsel <= 1;
			htrans <= 2'h2;
			haddr <= a;
			hwrite <= w;
			rdy_wait;
			hsel <= 0;
			htrans <= 2'h0;
			hwdata <= d;
			rdy_wait;
			v = hrdata;
		end
	endtask
	task wbit(input integer b);
		begin
			v = 0;
			for (k2 = 0; k2 < 400 && v[b] !== 1'b1; k2 = k2 + 1) bus(0, `I2CM_OFS_STAT, 0);
			if (v[b] !== 1'b1) begin
				err_count = err_count + 1;
				stop_test;
			end
		end
	endtask
	task xfer(input [7:0] d, input n, input s);
		begin
			nack <= n;
			str <= s;
			bus(1, `I2CM_OFS_STAT, 32'h73);
			bus(1, `I2CM_OFS_TXB, d);
			bus(0, `I2CM_OFS_STAT, 0);
			chk(v[`I2CM_ST_BF], 1);
			bus(1, `I2CM_OFS_TXB, ~d);
			bus(1, `I2CM_OFS_CTRL, 32'h2);
			wbit(`I2CM_ST_PIF);
			chk(v[5:0], {2'b01, n, 3'b000});
			chk(rx, d);
			chk(scl_oe, 1);
			bus(0, `I2CM_OFS_TXB, 0);
			chk(v[7:0], d);
			bus(0, `I2CM_OFS_CTRL, 0);
			chk(v, 0);
			$display("byte %h done", d);
		end
	endtask
	// ----------------------------------------
	// Clock and sequence
	// ----------------------------------------
	initial begin
		i_clk = 0;
		forever #25 i_clk = ~i_clk;
	end
	initial begin
		i_srst = 1;
		hsel = 0;
		hwrite = 0;
		htrans = 0;
		haddr = 0;
		hwdata = 0;
		nack = 0;
		str = 0;
		bpull = 0;
		v = 0;
		err_count = 0;
		n_compared = 0;
		repeat (6) @(posedge i_clk);
		i_srst <= 0;
		bus(0, `I2CM_OFS_BAUD, 0);
		chk(v, `I2CM_BAUD_RST);
		bus(1, 32'h10, 32'hFF);
		bus(0, 32'h10, 0);
		chk(v, 0);
		bus(1, `I2CM_OFS_BAUD, 32'h3);
		$display("registers done");
		bus(1, `I2CM_OFS_CTRL, 32'h1);
		bus(1, `I2CM_OFS_CTRL, 32'h4);
		bus(1, `I2CM_OFS_TXB, 32'hA5);
		wbit(`I2CM_ST_PIF);
		chk(v[4:0], 5'h11);
		chk(sda_oe, 1);
		bus(0, `I2CM_OFS_CTRL, 0);
		chk(v, 0);
		$display("start done");
		xfer(8'hA4, 0, 0);
		xfer(8'h5B, 1, 1);
		bus(1, `I2CM_OFS_STAT, 32'h73);
		bus(1, `I2CM_OFS_CTRL, 32'h2);
		wbit(`I2CM_ST_PIF);
		chk(v[0], 1);
		chk({scl_oe, sda_oe}, 2'h3);
		bus(0, `I2CM_OFS_CTRL, 0);
		chk(v, 0);
		$display("restart done");
		bus(1, `I2CM_OFS_STAT, 32'h73);
		bus(1, `I2CM_OFS_CTRL, 32'h4);
		wbit(`I2CM_ST_PIF);
		chk(v[1], 1);
		chk({scl_oe, sda_oe}, 2'h0);
		$display("stop done");
		bpull <= 1;
		bus(1, `I2CM_OFS_STAT, 32'h73);
		bus(1, `I2CM_OFS_CTRL, 32'h1);
		wbit(`I2CM_ST_BCOL);
		chk({scl_oe, sda_oe}, 2'h0);
		bus(0, `I2CM_OFS_CTRL, 0);
		chk(v, 0);
		bpull <= 0;
		$display("collision done");
		stop_test;
	end
endmodule // i2cm_top_tb
